/* File: scpu_unit.sv */
`timescale 1ns/1ps
// How it works
// RL1: every special cycle drives data_code low, memory_io low, write_read high.
// RL2: system logic answers each special cycle with burst_ready like a normal cycle.
// RL3: stop grant uses byte enables fb, address bits 4:3 = 10, rest zero.
// RL4: halt instruction yields halt cycle, byte enables fb, address bits 4:3 = 00.
// RL5: cache flush input: write back, invalidate, then flush acknowledge with ef.
// RL6: writeback-invalidate instruction: after cache work, writeback cycle with f7.
// RL7: either invalidation instruction issues cache flush cycle fd, address bits 00.
// RL8: fault during double fault: stop bus, shut down, issue cycle fe.
// RL9: system logic leaves shutdown via nmi, warm restart, reset or mgmt interrupt.
// RL10: descriptor values appear on the same edge address_strobe is asserted.
// RL11: stop request at boundary: flush pipe, finish bus cycles, then stop grant.
// RL12: internal clock stops only after stop grant ready and write buffer empty.
// RL13: system logic may halt the bus clock after stop grant.
// RL14: stop request sampled every edge, acted on at next instruction boundary.
// RL15: stop request held until stop grant completes; two clocks if asynchronous.
// RL16: warm restart empties pipelines, initialises state, fetches from reset address.
// RL17: warm restart keeps caches, fpu, msrs, cache control bits, time stamp.
// RL18: warm restart sampled every edge, acted on at next instruction boundary.
// RL19: system asserts warm restart three edges before io write burst_ready.
// RL20: warm restart held one clock synchronous, two after two negated if async.
// RL21: stop request negated and clock running: restart internal clock, resume.
module scpu_unit
  import scpu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // execution core events
  input wire logic instr_boundary,
  input wire logic halt_instruction,
  input wire logic writeback_invalidate_instr,
  input wire logic cache_discard_instr,
  input wire logic double_fault_fault,
  input wire logic pipe_empty,
  input wire logic bus_idle,
  input wire logic cache_work_done,
  // system inputs
  input wire logic cache_flush_in,
  input wire logic stop_clock_request,
  input wire logic warm_restart_request,
  input wire logic nonmaskable_interrupt_input,
  input wire logic system_mgmt_interrupt,
  input wire logic burst_ready,
  input wire logic external_write_buffer_empty,
  // bus outputs
  output logic address_strobe_n,
  output logic [7:0] byte_enables,
  output logic [SCPU_ADDR_W-1:0] address_lines,
  output logic data_code_select,
  output logic memory_io_select,
  output logic write_read_select,
  // core control
  output logic pipe_flush_req,
  output logic cache_work_req,
  output logic internal_clock_en,
  output logic warm_init_pulse,
  output logic resume_pulse,
  output logic halted,
  output logic shutdown_active
);
  scpu_state_t state_r;
  scpu_cyc_t kind_r;
  scpu_cyc_t enc_kind;
  logic stop_lvl_r;
  logic warm_lvl_r;
  logic flush_pend_r;
  logic writeback_invalidate_instr_r;
  logic rdy_seen_r;
  logic [7:0] enc_be;
  logic [1:0] enc_a43;

  scpu_encoder u_enc (
    .kind(enc_kind),
    .be(enc_be),
    .a43(enc_a43)
  );

  // level sampling of the requests on every edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stop_lvl_r <= 1'b0;
      warm_lvl_r <= 1'b0;
    end else begin
      stop_lvl_r <= stop_clock_request; // RL14
      // kept until acted on, so a one-clock request between boundaries is not lost
      warm_lvl_r <= warm_restart_request || (warm_lvl_r && state_r != SCPU_WARM_INIT); // RL18
    end
  end

  // flush input is a request that is remembered until acknowledged
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flush_pend_r <= 1'b0;
    end else if (cache_flush_in) begin
      flush_pend_r <= 1'b1; // set wins over clear
    end else if (state_r == SCPU_ISSUE && kind_r == SCPU_CYC_FLUSH_ACK) begin
      flush_pend_r <= 1'b0;
    end
  end

  // the second kind is chosen after a writeback cycle ends
  assign enc_kind = (state_r == SCPU_SECOND) ? SCPU_CYC_FLUSH : kind_r;

  // sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= SCPU_RUN;
      kind_r <= SCPU_CYC_HALT;
      writeback_invalidate_instr_r <= 1'b0;
      rdy_seen_r <= 1'b0;
    end else begin
      case (state_r)
        SCPU_RUN, SCPU_HALTED: begin
          if (double_fault_fault) begin
            kind_r <= SCPU_CYC_SHUTDOWN;
            state_r <= SCPU_ISSUE; // RL8
          end else if (instr_boundary && warm_lvl_r) begin
            state_r <= SCPU_WARM_INIT; // RL18
          end else if (instr_boundary && stop_lvl_r) begin
            kind_r <= SCPU_CYC_STOP_GRANT;
            state_r <= SCPU_DRAIN; // RL11
          end else if (flush_pend_r) begin
            kind_r <= SCPU_CYC_FLUSH_ACK;
            writeback_invalidate_instr_r <= 1'b0;
            state_r <= SCPU_CACHE_WORK; // RL5
          end else if (state_r == SCPU_RUN && writeback_invalidate_instr) begin
            kind_r <= SCPU_CYC_WRITEBACK;
            writeback_invalidate_instr_r <= 1'b1;
            state_r <= SCPU_CACHE_WORK; // RL6
          end else if (state_r == SCPU_RUN && cache_discard_instr) begin
            kind_r <= SCPU_CYC_FLUSH;
            writeback_invalidate_instr_r <= 1'b0;
            state_r <= SCPU_ISSUE; // RL7
          end else if (state_r == SCPU_RUN && halt_instruction) begin
            kind_r <= SCPU_CYC_HALT;
            state_r <= SCPU_ISSUE; // RL4
          end
        end
        SCPU_DRAIN: begin
          // pipe and outstanding bus cycles together, in either order
          if (pipe_empty && bus_idle) begin
            state_r <= SCPU_ISSUE; // RL11
          end
        end
        SCPU_CACHE_WORK: begin
          if (cache_work_done) begin
            state_r <= SCPU_ISSUE; // RL5 RL6
          end
        end
        SCPU_ISSUE, SCPU_SECOND: begin
          state_r <= SCPU_WAIT_READY;
        end
        SCPU_WAIT_READY: begin
          if (burst_ready) begin
            // completion relies on the system returning ready
            rdy_seen_r <= 1'b1; // RL2
            if (kind_r == SCPU_CYC_STOP_GRANT) begin
              state_r <= SCPU_WAIT_WBUF; // RL12
            end else if (kind_r == SCPU_CYC_SHUTDOWN) begin
              state_r <= SCPU_SHUTDOWN;
            end else if (kind_r == SCPU_CYC_HALT) begin
              state_r <= SCPU_HALTED;
            end else if (kind_r == SCPU_CYC_WRITEBACK && writeback_invalidate_instr_r) begin
              writeback_invalidate_instr_r <= 1'b0;
              kind_r <= SCPU_CYC_FLUSH;
              state_r <= SCPU_SECOND; // RL7
            end else begin
              state_r <= SCPU_RUN;
            end
          end
        end
        SCPU_WAIT_WBUF: begin
          if (rdy_seen_r && external_write_buffer_empty) begin
            rdy_seen_r <= 1'b0;
            state_r <= SCPU_STOPPED; // RL12
          end
        end
        SCPU_STOPPED: begin
          // bus clock may be held by the system; nothing moves here then
          if (!stop_lvl_r) begin
            state_r <= SCPU_RUN; // RL21
          end
        end
        SCPU_SHUTDOWN: begin
          if (warm_lvl_r) begin
            state_r <= SCPU_WARM_INIT; // RL9
          end else if (nonmaskable_interrupt_input || system_mgmt_interrupt) begin
            state_r <= SCPU_RUN; // RL9
          end
        end
        SCPU_WARM_INIT: begin
          state_r <= SCPU_RUN; // RL16
        end
        default: state_r <= SCPU_RUN;
      endcase
      if (state_r == SCPU_HALTED && (nonmaskable_interrupt_input || system_mgmt_interrupt)) begin
        state_r <= SCPU_RUN;
      end
    end
  end

  // bus drive: descriptors and strobe leave on the same edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      address_strobe_n <= 1'b1;
      byte_enables <= SCPU_BE_IDLE;
      address_lines <= SCPU_ADDR_ZERO;
      data_code_select <= SCPU_DC_RST;
      memory_io_select <= SCPU_MIO_RST;
      write_read_select <= SCPU_WR_RST;
    end else if (state_r == SCPU_ISSUE || state_r == SCPU_SECOND) begin
      address_strobe_n <= 1'b0; // RL10
      byte_enables <= enc_be;
      address_lines <= {{(SCPU_ADDR_W-2){1'b0}}, enc_a43}; // RL3
      data_code_select <= SCPU_DC_SPECIAL; // RL1
      memory_io_select <= SCPU_MIO_SPECIAL; // RL1
      write_read_select <= SCPU_WR_SPECIAL; // RL1
    end else begin
      address_strobe_n <= 1'b1;
    end
  end

  // core side controls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pipe_flush_req <= 1'b0;
      cache_work_req <= 1'b0;
      internal_clock_en <= 1'b1;
      warm_init_pulse <= 1'b0;
      resume_pulse <= 1'b0;
      halted <= 1'b0;
      shutdown_active <= 1'b0;
    end else begin
      pipe_flush_req <= (state_r == SCPU_DRAIN) || (state_r == SCPU_WARM_INIT); // RL11 RL16
      cache_work_req <= (state_r == SCPU_CACHE_WORK); // RL5
      internal_clock_en <= (state_r != SCPU_STOPPED); // RL12 RL21
      // only a pulse: caches, fpu, msrs and control bits are not touched here
      warm_init_pulse <= (state_r == SCPU_WARM_INIT); // RL16 RL17
      resume_pulse <= (state_r == SCPU_STOPPED) && !stop_lvl_r; // RL21
      halted <= (state_r == SCPU_HALTED);
      shutdown_active <= (state_r == SCPU_SHUTDOWN) || (kind_r == SCPU_CYC_SHUTDOWN && state_r != SCPU_RUN); // RL8
    end
  end
endmodule : scpu_unit

/* File: scpu_pkg.sv */
package scpu_pkg;
  // special cycle byte enable codes and the idle value
  localparam logic [7:0] SCPU_BE_STOP_GRANT = 8'hfb;
  localparam logic [7:0] SCPU_BE_FLUSH_ACK = 8'hef;
  localparam logic [7:0] SCPU_BE_WRITEBACK = 8'hf7;
  localparam logic [7:0] SCPU_BE_HALT = 8'hfb;
  localparam logic [7:0] SCPU_BE_FLUSH = 8'hfd;
  localparam logic [7:0] SCPU_BE_SHUTDOWN = 8'hfe;
  localparam logic [7:0] SCPU_BE_IDLE = 8'hff;
  // address bits four and three, the address width and the all-zero address
  localparam logic [1:0] SCPU_A43_STOP_GRANT = 2'h2;
  localparam logic [1:0] SCPU_A43_OTHER = 2'h0;
  localparam int SCPU_ADDR_W = 29;
  localparam logic [SCPU_ADDR_W-1:0] SCPU_ADDR_ZERO = 29'h0;
  // cycle descriptor values for special cycles
  localparam logic SCPU_DC_SPECIAL = 1'b0;
  localparam logic SCPU_MIO_SPECIAL = 1'b0;
  localparam logic SCPU_WR_SPECIAL = 1'b1;
  // reset values of the bus descriptor outputs
  localparam logic SCPU_DC_RST = 1'b0;
  localparam logic SCPU_MIO_RST = 1'b0;
  localparam logic SCPU_WR_RST = 1'b0;
  // cycle kinds
  typedef enum logic [2:0] {
    SCPU_CYC_STOP_GRANT = 3'b000,
    SCPU_CYC_FLUSH_ACK = 3'b001,
    SCPU_CYC_WRITEBACK = 3'b010,
    SCPU_CYC_HALT = 3'b011,
    SCPU_CYC_FLUSH = 3'b100,
    SCPU_CYC_SHUTDOWN = 3'b101
  } scpu_cyc_t;
  // sequencer states
  typedef enum logic [3:0] {
    SCPU_RUN = 4'b0000,
    SCPU_DRAIN = 4'b0001,
    SCPU_CACHE_WORK = 4'b0010,
    SCPU_ISSUE = 4'b0011,
    SCPU_WAIT_READY = 4'b0100,
    SCPU_WAIT_WBUF = 4'b0101,
    SCPU_STOPPED = 4'b0110,
    SCPU_HALTED = 4'b0111,
    SCPU_SHUTDOWN = 4'b1000,
    SCPU_WARM_INIT = 4'b1001,
    SCPU_SECOND = 4'b1010
  } scpu_state_t;
endpackage : scpu_pkg

/* File: scpu_encoder.sv */
`timescale 1ns/1ps
// maps a cycle kind to byte enables and the low address pair
module scpu_encoder
  import scpu_pkg::*;
(
  // kind
  input scpu_cyc_t kind,
  // encoding
  output logic [7:0] be,
  output logic [1:0] a43
);
  always_comb begin
    a43 = SCPU_A43_OTHER;
    case (kind)
      SCPU_CYC_STOP_GRANT: begin
        be = SCPU_BE_STOP_GRANT; // RL3
        a43 = SCPU_A43_STOP_GRANT; // RL3
      end
      SCPU_CYC_FLUSH_ACK: be = SCPU_BE_FLUSH_ACK; // RL5
      SCPU_CYC_WRITEBACK: be = SCPU_BE_WRITEBACK; // RL6
      SCPU_CYC_HALT: be = SCPU_BE_HALT; // RL4
      SCPU_CYC_FLUSH: be = SCPU_BE_FLUSH; // RL7
      SCPU_CYC_SHUTDOWN: be = SCPU_BE_SHUTDOWN; // RL8
      default: be = SCPU_BE_IDLE;
    endcase
  end
endmodule : scpu_encoder

/* File: scpu_assertions.sv */
`timescale 1ns/1ps
module scpu_assertions
  import scpu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // system inputs
  input wire logic stop_clock_request,
  input wire logic external_write_buffer_empty,
  // bus and core outputs
  input wire logic address_strobe_n,
  input wire logic [7:0] byte_enables,
  input wire logic [SCPU_ADDR_W-1:0] address_lines,
  input wire logic data_code_select,
  input wire logic memory_io_select,
  input wire logic write_read_select,
  input wire logic internal_clock_en,
  input wire logic halted
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wb;
    !address_strobe_n && byte_enables == SCPU_BE_WRITEBACK;
  endsequence
  sequence s_fl;
    !address_strobe_n && byte_enables == SCPU_BE_FLUSH;
  endsequence
  sequence s_halt;
    !address_strobe_n && byte_enables == SCPU_BE_HALT && address_lines == SCPU_ADDR_ZERO;
  endsequence
  a_desc_on_strobe: assert property (!address_strobe_n |->
    !data_code_select && !memory_io_select && write_read_select) else $error("special cycle descriptor wrong");
  a_strobe_one_cycle: assert property (!address_strobe_n |=> address_strobe_n)
    else $error("strobe longer than one cycle");
  a_stop_grant_enc: assert property (!address_strobe_n && address_lines[1:0] == SCPU_A43_STOP_GRANT |->
    byte_enables == SCPU_BE_STOP_GRANT && address_lines[SCPU_ADDR_W-1:2] == 0) else $error("stop grant code wrong");
  a_other_enc: assert property (!address_strobe_n && address_lines[1:0] != SCPU_A43_STOP_GRANT |->
    address_lines == SCPU_ADDR_ZERO && byte_enables inside {8'hfb, 8'hef, 8'hf7, 8'hfd, 8'hfe})
    else $error("special cycle code wrong");
  a_wb_then_flush: assert property (s_wb |-> ##[2:30] s_fl) else $error("no flush after writeback");
  a_halt_flag: assert property (s_halt |-> ##[1:30] halted) else $error("halt cycle without halted");
  a_stop_needs_req: assert property (!address_strobe_n && address_lines[1:0] == SCPU_A43_STOP_GRANT |->
    stop_clock_request) else $error("stop grant without request");
  a_clock_stop_wbuf: assert property ($fell(internal_clock_en) |-> $past(external_write_buffer_empty))
    else $error("clock stopped before write buffer empty");
  a_no_bus_stopped: assert property (!internal_clock_en |-> address_strobe_n)
    else $error("strobe while clock stopped");
  a_clock_restart: assert property (!internal_clock_en && !stop_clock_request |-> ##[0:8] internal_clock_en)
    else $error("clock not restarted");
endmodule : scpu_assertions

/* File: scpu_sys_model.sv */
`timescale 1ns/1ps
// chipset side: answers each special cycle with one ready after a chosen wait
module scpu_sys_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus
  input wire logic address_strobe_n,
  input wire logic [3:0] wait_states,
  output logic burst_ready
);
  logic [3:0] cnt_r;
  logic busy_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      burst_ready <= 1'b0;
    end else begin
      burst_ready <= 1'b0;
      if (!address_strobe_n) begin
        busy_r <= 1'b1;
        cnt_r <= wait_states;
      end else if (busy_r && cnt_r == 4'h0) begin
        burst_ready <= 1'b1;
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : scpu_sys_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import scpu_pkg::*;
  logic clock = 0, rst = 1, instr_boundary = 1, halt_instruction = 0, writeback_invalidate_instr = 0;
  logic cache_discard_instr = 0, double_fault_fault = 0, pipe_empty = 1, bus_idle = 1, cache_work_done = 0;
  logic cache_flush_in = 0, stop_clock_request = 0, warm_restart_request = 0, nonmaskable_interrupt_input = 0;
  logic system_mgmt_interrupt = 0, external_write_buffer_empty = 1, burst_ready;
  logic address_strobe_n, data_code_select, memory_io_select, write_read_select, pipe_flush_req;
  logic cache_work_req, internal_clock_en, warm_init_pulse, resume_pulse, halted, shutdown_active;
  logic [7:0] byte_enables;
  logic [SCPU_ADDR_W-1:0] address_lines;
  logic [3:0] wait_states = 4'h0;
  int mismatches = 0, n_checks = 0, n_done = 0, cycles = 0, k;
  scpu_unit i_dut (.*);
  scpu_sys_model i_sys (.clock, .rst, .address_strobe_n, .wait_states, .burst_ready);
  initial begin
    forever #20 clock = ~clock;
  end
  // cache work finishes one cycle after it is asked for
  always @(posedge clock) begin
    cache_work_done <= cache_work_req && !cache_work_done;
    n_done <= n_done + int'(cache_work_done);
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      print_verdict();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task expect_cycle(input string what, input logic [7:0] be, input logic [1:0] a43);
    int i;
    i = 0;
    do begin
      tick(1);
      i++;
    end while (address_strobe_n !== 1'b0 && i < 60);
    chk({what, " strobe"}, 32'h0, {31'h0, address_strobe_n});
    chk({what, " be"}, {24'h0, be}, {24'h0, byte_enables});
    chk({what, " addr"}, {30'h0, a43}, {3'h0, address_lines});
    chk({what, " desc"}, 32'h1, {29'h0, data_code_select, memory_io_select, write_read_select});
  endtask : expect_cycle
  task t_halt;
    @(posedge clock) halt_instruction <= 1'b1;
    @(posedge clock) halt_instruction <= 1'b0;
    expect_cycle("halt", SCPU_BE_HALT, SCPU_A43_OTHER);
    tick(8);
    chk("halted", 32'h1, {31'h0, halted});
    @(posedge clock) nonmaskable_interrupt_input <= 1'b1;
    @(posedge clock) nonmaskable_interrupt_input <= 1'b0;
    tick(4);
    chk("halt left", 32'h0, {31'h0, halted});
    $display("test halt done");
  endtask : t_halt
  task t_flush_ack;
    k = n_done;
    @(posedge clock) cache_flush_in <= 1'b1;
    @(posedge clock) cache_flush_in <= 1'b0;
    expect_cycle("flush ack", SCPU_BE_FLUSH_ACK, SCPU_A43_OTHER);
    chk("work before ack", 32'h1, {31'h0, n_done > k});
    tick(8);
    $display("test flush ack done");
  endtask : t_flush_ack
  task t_writeback_invalidate_instr;
    k = n_done;
    @(posedge clock) writeback_invalidate_instr <= 1'b1;
    @(posedge clock) writeback_invalidate_instr <= 1'b0;
    expect_cycle("writeback", SCPU_BE_WRITEBACK, SCPU_A43_OTHER);
    chk("work before wb", 32'h1, {31'h0, n_done > k});
    expect_cycle("wb flush", SCPU_BE_FLUSH, SCPU_A43_OTHER);
    // instructions are only taken once the flush cycle has been answered
    tick(4);
    @(posedge clock) cache_discard_instr <= 1'b1;
    @(posedge clock) cache_discard_instr <= 1'b0;
    expect_cycle("discard", SCPU_BE_FLUSH, SCPU_A43_OTHER);
    tick(8);
    $display("test cache cycles done");
  endtask : t_writeback_invalidate_instr
  task t_shutdown;
    @(posedge clock) double_fault_fault <= 1'b1;
    @(posedge clock) double_fault_fault <= 1'b0;
    expect_cycle("shutdown", SCPU_BE_SHUTDOWN, SCPU_A43_OTHER);
    tick(6);
    chk("shutdown on", 32'h1, {31'h0, shutdown_active});
    @(posedge clock) system_mgmt_interrupt <= 1'b1;
    @(posedge clock) system_mgmt_interrupt <= 1'b0;
    tick(6);
    chk("shutdown off", 32'h0, {31'h0, shutdown_active});
    $display("test shutdown done");
  endtask : t_shutdown
  task t_stop;
    @(posedge clock) begin
      wait_states <= 4'h3;
      bus_idle <= 1'b0;
      pipe_empty <= 1'b0;
      external_write_buffer_empty <= 1'b0;
      stop_clock_request <= 1'b1;
    end
    tick(10);
    chk("drain flush", 32'h1, {31'h0, pipe_flush_req});
    chk("no early grant", 32'h1, {31'h0, address_strobe_n});
    @(posedge clock) pipe_empty <= 1'b1;
    tick(3);
    chk("wait bus idle", 32'h1, {31'h0, address_strobe_n});
    @(posedge clock) bus_idle <= 1'b1;
    expect_cycle("stop grant", SCPU_BE_STOP_GRANT, SCPU_A43_STOP_GRANT);
    tick(12);
    chk("clock held", 32'h1, {31'h0, internal_clock_en});
    @(posedge clock) external_write_buffer_empty <= 1'b1;
    tick(5);
    chk("clock stopped", 32'h0, {31'h0, internal_clock_en});
    // the bus clock is left running while stopped
    @(posedge clock) stop_clock_request <= 1'b0;
    tick(2);
    chk("resume pulse", 32'h1, {31'h0, resume_pulse});
    tick(6);
    chk("clock back", 32'h1, {31'h0, internal_clock_en});
    @(posedge clock) wait_states <= 4'h0;
    $display("test stop grant done");
  endtask : t_stop
  task t_warm;
    int i;
    i = 0;
    @(posedge clock) begin
      instr_boundary <= 1'b0;
      warm_restart_request <= 1'b1;
    end
    @(posedge clock) warm_restart_request <= 1'b0;
    tick(3);
    chk("warm waits boundary", 32'h0, {31'h0, warm_init_pulse});
    @(posedge clock) instr_boundary <= 1'b1;
    while (warm_init_pulse !== 1'b1 && i < 10) begin
      tick(1);
      i++;
    end
    chk("warm init", 32'h1, {31'h0, warm_init_pulse});
    chk("warm flush", 32'h1, {31'h0, pipe_flush_req});
    tick(10);
    @(posedge clock) double_fault_fault <= 1'b1;
    @(posedge clock) double_fault_fault <= 1'b0;
    expect_cycle("shutdown 2", SCPU_BE_SHUTDOWN, SCPU_A43_OTHER);
    tick(6);
    chk("shutdown 2 on", 32'h1, {31'h0, shutdown_active});
    @(posedge clock) warm_restart_request <= 1'b1;
    @(posedge clock) warm_restart_request <= 1'b0;
    tick(4);
    chk("warm off shutdown", 32'h0, {31'h0, shutdown_active});
    tick(4);
    $display("test warm restart done");
  endtask : t_warm
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_halt();
    t_flush_ack();
    t_writeback_invalidate_instr();
    t_shutdown();
    t_stop();
    t_warm();
    print_verdict();
  end
endmodule : testbench
bind scpu_unit scpu_assertions i_chk (.clock, .rst, .stop_clock_request, .external_write_buffer_empty,
  .address_strobe_n, .byte_enables, .address_lines, .data_code_select, .memory_io_select,
  .write_read_select, .internal_clock_en, .halted);
